// [pas_pkg.sv]
// Package for the PWM auto-shutdown block: register map, fields, codes.
// Assumes a 32-bit AXI4-Lite register bus and a 20 MHz system clock.
package pas_pkg;
    localparam logic [3:0]  ADDR_CTRL      = 4'h0;
    localparam logic [3:0]  ADDR_IRQ_STAT  = 4'h4;
    localparam logic [3:0]  ADDR_IRQ_MASK  = 4'h8;
    localparam logic [3:0]  ADDR_CFG       = 4'hC;
    localparam logic [7:0]  CTRL_RESET     = 8'h00;
    localparam int          FLAG_BIT       = 7;
    localparam int          SEL_HI         = 6;
    localparam int          SEL_LO         = 4;
    localparam int          AC_HI          = 3;
    localparam int          AC_LO          = 2;
    localparam int          BD_HI          = 1;
    localparam int          BD_LO          = 0;
    localparam int          NUM_IRQ        = 2;
    localparam int          IRQ_SHUTDOWN   = 0;
    localparam int          IRQ_SUPPRESS   = 1;
    localparam int          NUM_CFG        = 4;
    localparam int          CFG_PWM_MODE   = 0;
    localparam int          CFG_CMP1_EN    = 1;
    localparam int          CFG_CMP2_EN    = 2;
    localparam int          CFG_IRQ0_EN    = 3;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;
    localparam logic [1:0]  SAFE_LOW       = 2'h0;
    localparam logic [1:0]  SAFE_HIGH      = 2'h1;
    localparam logic [2:0]  SEL_OFF        = 3'h0;
    localparam logic [2:0]  SEL_C1         = 3'h1;
    localparam logic [2:0]  SEL_C2         = 3'h2;
    localparam logic [2:0]  SEL_C12        = 3'h3;
    localparam logic [2:0]  SEL_I0         = 3'h4;
    localparam logic [2:0]  SEL_I0_C1      = 3'h5;
    localparam logic [2:0]  SEL_I0_C2      = 3'h6;
    localparam logic [2:0]  SEL_I0_C12     = 3'h7;
endpackage

// [pas_src_sel.sv]
// Shutdown source selection, purely combinational.
// Assumes comparator and interrupt inputs already synchronised or raw async.
`timescale 1ns/10ps
module pas_src_sel
    import pas_pkg::*;
(
    input  wire logic [2:0] sel_i,
    input  wire logic       cmp1_i,
    input  wire logic       cmp2_i,
    input  wire logic       irq0_i,
    input  wire logic       cmp1_en_i,
    input  wire logic       cmp2_en_i,
    input  wire logic       irq0_en_i,
    output logic            event_o
);
    logic c1;
    logic c2;
    logic i0;
    always_comb begin
        c1 = cmp1_i & cmp1_en_i;
        c2 = cmp2_i & cmp2_en_i;
        i0 = irq0_i & irq0_en_i;
        unique case (sel_i)
            SEL_OFF:    event_o = 1'b0;
            SEL_C1:     event_o = c1;
            SEL_C2:     event_o = c2;
            SEL_C12:    event_o = c1 | c2;
            SEL_I0:     event_o = i0;
            SEL_I0_C1:  event_o = i0 | c1;
            SEL_I0_C2:  event_o = i0 | c2;
            SEL_I0_C12: event_o = i0 | c1 | c2;
        endcase
    end
endmodule // pas_src_sel

// [pas_pin_gate.sv]
// Combinational pin gate for one pin pair under shutdown.
// Assumes shutdown is an asynchronous level from the top module.
`timescale 1ns/10ps
module pas_pin_gate
    import pas_pkg::*;
(
    input  wire logic       shutdown_i,
    input  wire logic [1:0] safe_i,
    input  wire logic [1:0] pwm_i,
    input  wire logic [1:0] pwm_oe_i,
    output logic      [1:0] pin_o,
    output logic      [1:0] pin_oe_o
);
    always_comb begin
        if (shutdown_i) begin
            pin_o    = (safe_i == SAFE_HIGH) ? 2'h3 : 2'h0;
            pin_oe_o = safe_i[1] ? 2'h0 : 2'h3;
        end else begin
            pin_o    = pwm_i;
            pin_oe_o = pwm_oe_i;
        end
    end
endmodule // pas_pin_gate

// [pas_top.sv]
// PWM auto-shutdown: control register, event flag, period suppression, pin gating.
// Assumes PWM waveform, period start strobe and comparators live outside on CLK_SYS_I.
// Function
// - Shutdown reaches the pins only while the unit is in a PWM mode.
// - Selected comparator or interrupt source disables the outputs asynchronously.
// - Interrupt zero counts as a source only when its enable is set.
// - A comparator counts as a source only when that comparator is enabled.
// - On shutdown each pin pair is driven to its programmed safe state.
// - Shutdown gates outputs combinationally, without waiting for a clock edge.
// - A period starting while a live event or the event flag holds shutdown is suppressed entirely.
// - Hardware sets the event flag; only software write clears it.
// - After a latched event, outputs stay disabled until software clears the event flag and any suppressed period ends.
// - Software writing one to the event flag forces shutdown.
//
// Register access over AXI4-Lite and the address map were decided locally.
`timescale 1ns/10ps
module pas_top
    import pas_pkg::*;
(
    input  wire logic        CLK_SYS_I,
    input  wire logic        NRST_I,
    input  wire logic        S_AXI_AWVALID_I,
    output logic             S_AXI_AWREADY_O,
    input  wire logic [3:0]  S_AXI_AWADDR_I,
    input  wire logic        S_AXI_WVALID_I,
    output logic             S_AXI_WREADY_O,
    input  wire logic [31:0] S_AXI_WDATA_I,
    input  wire logic [3:0]  S_AXI_WSTRB_I,
    output logic             S_AXI_BVALID_O,
    input  wire logic        S_AXI_BREADY_I,
    output logic [1:0]       S_AXI_BRESP_O,
    input  wire logic        S_AXI_ARVALID_I,
    output logic             S_AXI_ARREADY_O,
    input  wire logic [3:0]  S_AXI_ARADDR_I,
    output logic             S_AXI_RVALID_O,
    input  wire logic        S_AXI_RREADY_I,
    output logic [31:0]      S_AXI_RDATA_O,
    output logic [1:0]       S_AXI_RRESP_O,
    input  wire logic        CMP1_OUT_I,
    input  wire logic        CMP2_OUT_I,
    input  wire logic        EXTERNAL_IRQ_ZERO_I,
    input  wire logic        PERIOD_START_I,
    input  wire logic [3:0]  PWM_I,
    input  wire logic [3:0]  PWM_OE_I,
    output logic [3:0]       PIN_O,
    output logic [3:0]       PIN_OE_O,
    output logic             SHUTDOWN_O,
    output logic             IRQ_O
);
    typedef struct packed {
        logic [7:0]         ctrl;
        logic [NUM_CFG-1:0] cfg;
        logic [NUM_IRQ-1:0] irq_stat;
        logic [NUM_IRQ-1:0] irq_mask;
        logic               suppress;
        logic               aw_held;
        logic [3:0]         aw_addr;
        logic               w_held;
        logic [31:0]        w_data;
        logic               w_lane0;
        logic               bvalid;
        logic [1:0]         bresp;
        logic               rvalid;
        logic [31:0]        rdata;
        logic [1:0]         rresp;
        logic [2:0]         sync1;
        logic [2:0]         sync2;
        logic [2:0]         sync3;
        logic [2:0]         sync_ok;
    } pas_state_t;

    pas_state_t st;
    pas_state_t next_st;

    logic       raw_event;
    logic       sync_event;
    logic       pwm_mode;
    logic       shutdown;
    logic       sd_cause;
    logic       do_write;
    logic       wr_ctrl;
    logic [3:0] pin_a_c;
    logic [3:0] pin_oe_a_c;
    logic [1:0] safe_ac;
    logic [1:0] safe_bd;

    assign pwm_mode = st.cfg[CFG_PWM_MODE];
    assign safe_ac  = st.ctrl[AC_HI:AC_LO];
    assign safe_bd  = st.ctrl[BD_HI:BD_LO];

    // Asynchronous source path to the pins
    pas_src_sel u_src_raw (
        .sel_i     (st.ctrl[SEL_HI:SEL_LO]),
        .cmp1_i    (CMP1_OUT_I),
        .cmp2_i    (CMP2_OUT_I),
        .irq0_i    (EXTERNAL_IRQ_ZERO_I),
        .cmp1_en_i (st.cfg[CFG_CMP1_EN]),
        .cmp2_en_i (st.cfg[CFG_CMP2_EN]),
        .irq0_en_i (st.cfg[CFG_IRQ0_EN]),
        .event_o   (raw_event)
    );

    // Filtered copy latches the flag; a change counts once stages two and three agree
    pas_src_sel u_src_sync (
        .sel_i     (st.ctrl[SEL_HI:SEL_LO]),
        .cmp1_i    (st.sync_ok[0]),
        .cmp2_i    (st.sync_ok[1]),
        .irq0_i    (st.sync_ok[2]),
        .cmp1_en_i (st.cfg[CFG_CMP1_EN]),
        .cmp2_en_i (st.cfg[CFG_CMP2_EN]),
        .irq0_en_i (st.cfg[CFG_IRQ0_EN]),
        .event_o   (sync_event)
    );

    // Live event or flag; a suppressed period also holds the pins safe
    assign sd_cause = pwm_mode & (raw_event | st.ctrl[FLAG_BIT]);
    // Suppress must not feed its own reload, or it would never release
    assign shutdown = sd_cause | (pwm_mode & st.suppress);

    pas_pin_gate u_gate_ac (
        .shutdown_i (shutdown),
        .safe_i     (safe_ac),
        .pwm_i      ({PWM_I[2], PWM_I[0]}),
        .pwm_oe_i   ({PWM_OE_I[2], PWM_OE_I[0]}),
        .pin_o      ({pin_a_c[2], pin_a_c[0]}),
        .pin_oe_o   ({pin_oe_a_c[2], pin_oe_a_c[0]})
    );

    pas_pin_gate u_gate_bd (
        .shutdown_i (shutdown),
        .safe_i     (safe_bd),
        .pwm_i      ({PWM_I[3], PWM_I[1]}),
        .pwm_oe_i   ({PWM_OE_I[3], PWM_OE_I[1]}),
        .pin_o      ({pin_a_c[3], pin_a_c[1]}),
        .pin_oe_o   ({pin_oe_a_c[3], pin_oe_a_c[1]})
    );

    assign PIN_O      = pin_a_c;
    assign PIN_OE_O   = pin_oe_a_c;
    assign SHUTDOWN_O = shutdown;
    assign IRQ_O      = |(st.irq_stat & st.irq_mask);

    assign S_AXI_AWREADY_O = ~st.aw_held;
    assign S_AXI_WREADY_O  = ~st.w_held;
    assign S_AXI_BVALID_O  = st.bvalid;
    assign S_AXI_BRESP_O   = st.bresp;
    assign S_AXI_ARREADY_O = ~st.rvalid;
    assign S_AXI_RVALID_O  = st.rvalid;
    assign S_AXI_RDATA_O   = st.rdata;
    assign S_AXI_RRESP_O   = st.rresp;

    assign do_write = st.aw_held & st.w_held & ~st.bvalid;
    assign wr_ctrl  = do_write & (st.aw_addr == ADDR_CTRL) & st.w_lane0;

    always_comb begin
        next_st = st;
        next_st.sync1 = {EXTERNAL_IRQ_ZERO_I, CMP2_OUT_I, CMP1_OUT_I};
        next_st.sync2 = st.sync1;
        next_st.sync3 = st.sync2;
        next_st.sync_ok = (st.sync2 & st.sync3) | (st.sync_ok & (st.sync2 | st.sync3));

        if (S_AXI_AWVALID_I && !st.aw_held) begin
            next_st.aw_held = 1'b1;
            next_st.aw_addr = S_AXI_AWADDR_I;
        end
        if (S_AXI_WVALID_I && !st.w_held) begin
            next_st.w_held  = 1'b1;
            next_st.w_data  = S_AXI_WDATA_I;
            next_st.w_lane0 = S_AXI_WSTRB_I[0];
        end

        if (do_write) begin
            next_st.bvalid  = 1'b1;
            next_st.bresp   = RESP_OKAY;
            next_st.aw_held = 1'b0;
            next_st.w_held  = 1'b0;
            if (st.w_lane0) begin
                unique case (st.aw_addr)
                    ADDR_CTRL:     next_st.ctrl     = st.w_data[7:0];
                    ADDR_IRQ_STAT: next_st.irq_stat = st.irq_stat & ~st.w_data[NUM_IRQ-1:0];
                    ADDR_IRQ_MASK: next_st.irq_mask = st.w_data[NUM_IRQ-1:0];
                    ADDR_CFG:      next_st.cfg      = st.w_data[NUM_CFG-1:0];
                    default:       next_st.bresp    = RESP_SLVERR;
                endcase
            end else if (st.aw_addr != ADDR_CTRL && st.aw_addr != ADDR_IRQ_STAT
                         && st.aw_addr != ADDR_IRQ_MASK && st.aw_addr != ADDR_CFG) begin
                next_st.bresp = RESP_SLVERR;
            end
        end else if (st.bvalid && S_AXI_BREADY_I) begin
            next_st.bvalid = 1'b0;
        end

        // Hardware set beats the software clear in the same cycle.
        // Only the filtered copy reaches the flag; a glitch under one clock gates pins but does not set the flag.
        if (pwm_mode && sync_event) begin
            next_st.ctrl[FLAG_BIT] = 1'b1;
        end

        // Period boundary: suppress whole period while shutdown persists
        if (PERIOD_START_I) begin
            next_st.suppress = sd_cause;
        end

        if (pwm_mode && !st.ctrl[FLAG_BIT] && next_st.ctrl[FLAG_BIT]) begin
            next_st.irq_stat[IRQ_SHUTDOWN] = 1'b1;
        end
        if (PERIOD_START_I && sd_cause) begin
            next_st.irq_stat[IRQ_SUPPRESS] = 1'b1;
        end

        if (S_AXI_ARVALID_I && !st.rvalid) begin
            next_st.rvalid = 1'b1;
            next_st.rresp  = RESP_OKAY;
            next_st.rdata  = 32'h0000_0000;
            unique case (S_AXI_ARADDR_I)
                ADDR_CTRL:     next_st.rdata[7:0]         = st.ctrl;
                ADDR_IRQ_STAT: next_st.rdata[NUM_IRQ-1:0] = st.irq_stat;
                ADDR_IRQ_MASK: next_st.rdata[NUM_IRQ-1:0] = st.irq_mask;
                ADDR_CFG:      next_st.rdata[NUM_CFG-1:0] = st.cfg;
                default:       next_st.rresp              = RESP_SLVERR;
            endcase
        end else if (st.rvalid && S_AXI_RREADY_I) begin
            next_st.rvalid = 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
        if (!NRST_I) begin
            st      <= '0;
            st.ctrl <= CTRL_RESET;
        end else begin
            st <= next_st;
        end
    end

    // Assertions
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!NRST_I);

    mode_gate_a: assert property (!pwm_mode |-> PIN_O == PWM_I && PIN_OE_O == PWM_OE_I)
        else $error("pins gated outside pwm mode");
    async_gate_a: assert property (pwm_mode && raw_event |-> SHUTDOWN_O)
        else $error("live event did not gate pins");
    irq0_enable_a: assert property (!st.cfg[CFG_IRQ0_EN] && st.ctrl[SEL_HI:SEL_LO] == SEL_I0 |-> !raw_event)
        else $error("disabled interrupt zero caused shutdown");
    cmp_enable_a: assert property (!st.cfg[CFG_CMP1_EN] && st.ctrl[SEL_HI:SEL_LO] == SEL_C1 |-> !raw_event)
        else $error("disabled comparator caused shutdown");
    safe_low_a: assert property (shutdown && safe_ac == SAFE_LOW |-> PIN_O[0] == 1'b0 && PIN_OE_O[0])
        else $error("pin A not driven low");
    safe_tri_a: assert property (shutdown && safe_bd[1] |-> PIN_OE_O[1] == 1'b0 && PIN_OE_O[3] == 1'b0)
        else $error("pins B D not tristated");
    period_sup_a: assert property (PERIOD_START_I && sd_cause |=> SHUTDOWN_O throughout (!PERIOD_START_I [*1]))
        else $error("suppressed period not held");
    flag_set_a: assert property (pwm_mode && sync_event |=> st.ctrl[FLAG_BIT])
        else $error("event flag not set");
    flag_hold_a: assert property (st.ctrl[FLAG_BIT] && !wr_ctrl |=> st.ctrl[FLAG_BIT])
        else $error("flag cleared without software");
    force_sd_a: assert property (wr_ctrl && st.w_data[FLAG_BIT] && pwm_mode |=> SHUTDOWN_O)
        else $error("software force did not shut down");
    sel_101_a: assert property (st.ctrl[SEL_HI:SEL_LO] == SEL_I0_C1 && st.cfg[CFG_CMP1_EN] && CMP1_OUT_I
                                |-> raw_event)
        else $error("code 101 ignored comparator 1");
    sel_off_a: assert property (st.ctrl[SEL_HI:SEL_LO] == SEL_OFF |-> !raw_event)
        else $error("code 000 caused shutdown");
    sup_release_a: assert property (PERIOD_START_I && !sd_cause |=> !st.suppress)
        else $error("suppress not released at clean period");
    cmp2_enable_a: assert property (!st.cfg[CFG_CMP2_EN] && st.ctrl[SEL_HI:SEL_LO] == SEL_C2 |-> !raw_event)
        else $error("disabled comparator 2 caused shutdown");
    sel_100_a: assert property (st.ctrl[SEL_HI:SEL_LO] == SEL_I0 && !EXTERNAL_IRQ_ZERO_I |-> !raw_event)
        else $error("code 100 took a comparator");
    safe_high_a: assert property (shutdown && safe_bd == SAFE_HIGH |-> PIN_O[1] && PIN_O[3] && PIN_OE_O[1] && PIN_OE_O[3])
        else $error("pins B D not driven high");

    hw_sd_c: cover property (pwm_mode && raw_event ##1 st.ctrl[FLAG_BIT]);
    sw_clear_c: cover property (st.ctrl[FLAG_BIT] ##1 !st.ctrl[FLAG_BIT]);
    sup_c: cover property (PERIOD_START_I && sd_cause);
    irq_c: cover property (IRQ_O);
endmodule // pas_top

// [pas_far_model.sv]
// Far-side model: PWM generator with period strobe and shutdown event sources.
// Assumes one clock; event lines follow the bench command one edge later.
`timescale 1ns/10ps
module pas_far_model
    import pas_pkg::*;
#(
    parameter int PER = 16
)
(
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    input  wire logic [2:0] ev_i,
    output logic            cmp1_o,
    output logic            cmp2_o,
    output logic            irq0_o,
    output logic            start_o,
    output logic [3:0]      pwm_o,
    output logic [3:0]      pwm_oe_o
);
    logic [7:0] cnt;
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt      <= 8'h00;
            start_o  <= 1'b0;
            pwm_o    <= 4'h0;
            pwm_oe_o <= 4'h0;
            {irq0_o, cmp2_o, cmp1_o} <= 3'h0;
        end else begin
            cnt      <= (cnt == 8'(PER - 1)) ? 8'h00 : cnt + 8'h01;
            start_o  <= (cnt == 8'(PER - 1));
            pwm_o    <= (cnt < 8'h05) ? 4'h5 : 4'hA;
            pwm_oe_o <= 4'hF ^ {3'h0, cnt[3]};
            {irq0_o, cmp2_o, cmp1_o} <= ev_i;
        end
    end
endmodule // pas_far_model

// [pas_top_tb.sv]
// Self-checking bench for the PWM auto-shutdown block.
// Assumes the far-side model and an AXI4-Lite master made of tasks.
`timescale 1ns/10ps
module pas_top_tb
    import pas_pkg::*;
;
    localparam int PER = 16;
    logic clk, nrst, awv, wv, arv, bready, rready, awr, wrd, bv, arr, rv;
    logic start, sd, irq, c1, c2, i0;
    logic [3:0] awa, ara, pwm, pwm_oe, pin, pin_oe;
    logic [31:0] wd, rdat, d;
    logic [1:0] br, rr, r, ac, bd;
    logic [2:0] ev, en;
    logic [15:0] seed;
    logic e;
    int n_errors, tests_run, cycles;

    pas_far_model #(.PER(PER)) far (.clk_i(clk), .nrst_i(nrst), .ev_i(ev), .cmp1_o(c1), .cmp2_o(c2),
        .irq0_o(i0), .start_o(start), .pwm_o(pwm), .pwm_oe_o(pwm_oe));
    pas_top dut (.CLK_SYS_I(clk), .NRST_I(nrst), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr),
        .S_AXI_AWADDR_I(awa), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrd), .S_AXI_WDATA_I(wd),
        .S_AXI_WSTRB_I(4'hF), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bready), .S_AXI_BRESP_O(br),
        .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr), .S_AXI_ARADDR_I(ara), .S_AXI_RVALID_O(rv),
        .S_AXI_RREADY_I(rready), .S_AXI_RDATA_O(rdat), .S_AXI_RRESP_O(rr), .CMP1_OUT_I(c1),
        .CMP2_OUT_I(c2), .EXTERNAL_IRQ_ZERO_I(i0), .PERIOD_START_I(start), .PWM_I(pwm),
        .PWM_OE_I(pwm_oe), .PIN_O(pin), .PIN_OE_O(pin_oe), .SHUTDOWN_O(sd), .IRQ_O(irq));

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [7:0] pexp(input logic s, input logic [1:0] a, input logic [1:0] b);
        logic [1:0] st;
        pexp = {pwm_oe, pwm};
        for (int i = 0; i < 4; i++) begin
            st = i[0] ? b : a;
            if (s) begin
                pexp[4 + i] = !st[1];
                pexp[i] = !st[1] & st[0];
            end
        end
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic pchk(input logic s, input logic [1:0] a, input logic [1:0] b);
        logic [7:0] x;
        x = pexp(s, a, b);
        chk({23'h0, sd, pin_oe, pin & x[7:4]}, {23'h0, s, x[7:4], x[3:0] & x[7:4]}, "pins");
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        logic ao, wo, bo;
        logic [1:0] rsp;
        awv <= 1'b1; awa <= a; wv <= 1'b1; wd <= v; bready <= 1'b1;
        do begin
            @(negedge clk);
            ao = awv && awr; wo = wv && wrd; bo = bv; rsp = br;
            @(posedge clk);
            if (ao) awv <= 1'b0;
            if (wo) wv <= 1'b0;
        end while (!bo);
        chk({30'h0, rsp}, {30'h0, RESP_OKAY}, "bresp");
    endtask
    task automatic rd(input logic [3:0] a);
        logic ao, ro;
        arv <= 1'b1; ara <= a; rready <= 1'b1;
        do begin
            @(negedge clk);
            ao = arv && arr; ro = rv; d = rdat; r = rr;
            @(posedge clk);
            if (ao) arv <= 1'b0;
        end while (!ro);
    endtask
    task automatic clear_chk(input logic s, input logic [7:0] c);
        do @(negedge clk); while (start !== 1'b1);
        @(posedge clk);
        wr(ADDR_CTRL, {24'h0, c});
        @(negedge clk);
        chk({31'h0, sd}, {31'h0, s}, "suppress");
        do @(negedge clk); while (start !== 1'b1);
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk({31'h0, sd}, 32'h0, "restore");
        @(posedge clk);
    endtask
    task automatic give_verdict;
        $display("Checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            give_verdict;
        end
    end
    initial begin
        {awv, wv, arv, bready, rready, nrst} = 6'h0;
        {awa, ara, wd, ev} = '0;
        seed = 16'h0049;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rd(ADDR_CTRL); chk(d, 32'h0, "ctrl rst");
        rd(ADDR_CFG); chk(d, 32'h0, "cfg rst");
        rd(4'h2); chk({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped");
        wr(ADDR_CFG, 32'hE);
        wr(ADDR_CTRL, 32'h70);
        ev <= 3'h7;
        repeat (4) @(posedge clk);
        @(negedge clk); pchk(1'b0, 2'h0, 2'h0);
        @(posedge clk);
        ev <= 3'h0;
        // Let the filtered event copies drain before pwm mode comes on
        repeat (6) @(posedge clk);
        rd(ADDR_CTRL); chk(d, 32'h70, "no mode");
        for (int sel = 0; sel < 8; sel++) begin
            for (int s = 0; s < 3; s++) begin
                seed = lfsr(seed);
                en = seed[2:0]; ac = seed[4:3]; bd = seed[6:5];
                e = |(3'(sel) & (3'h1 << s) & en);
                wr(ADDR_CFG, {28'h0, en, 1'b1});
                wr(ADDR_CTRL, {25'h0, 3'(sel), ac, bd});
                ev <= 3'h1 << s;
                @(posedge clk);
                @(negedge clk); pchk(e, ac, bd);
                repeat (PER + 4) @(posedge clk);
                ev <= 3'h0;
                repeat (3) @(posedge clk);
                rd(ADDR_CTRL); chk(d, {24'h0, e, 3'(sel), ac, bd}, "flag");
                @(negedge clk); pchk(e, ac, bd);
                @(posedge clk);
                clear_chk(e, {1'b0, 3'(sel), ac, bd});
            end
        end
        wr(ADDR_CTRL, 32'h86);
        @(negedge clk); pchk(1'b1, 2'h1, 2'h2);
        @(posedge clk);
        clear_chk(1'b1, 8'h06);
        rd(ADDR_IRQ_STAT); chk(d, 32'h3, "stat");
        chk({31'h0, irq}, 32'h0, "masked");
        wr(ADDR_IRQ_MASK, 32'h3);
        @(negedge clk); chk({31'h0, irq}, 32'h1, "irq");
        @(posedge clk);
        wr(ADDR_IRQ_STAT, 32'h3);
        rd(ADDR_IRQ_STAT); chk(d, 32'h0, "w1c");
        @(negedge clk); chk({31'h0, irq}, 32'h0, "irq off");
        give_verdict;
    end
endmodule // pas_top_tb
